//--- pcp_pkg.sv
package pcp_pkg;

  // Pin bus widths
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // Address map
  localparam logic [4:0] PAGE_SEL_ADDR = 5'h0F;
  localparam logic [4:0] PAGED_BASE    = 5'h10;
  localparam int         GLOBAL_SPAN   = 16;
  localparam int         GLOBAL_REGS   = 8;
  localparam int         PAGE_COUNT    = 64;
  localparam int         PAGE_SIZE     = 16;
  localparam int         CTRL_REGS     = 110;
  localparam int         PAGE_IDX_W    = 6;
  localparam int         OFS_W         = 4;

  // Reset values
  localparam logic [7:0] PAGE_SEL_RESET = 8'h00;
  localparam logic [7:0] REG_RESET      = 8'h00;

  // Pin sampler: strap, ce, rd, wr, addr, data
  localparam int          SYNC_STAGES = 3;
  localparam int          PIN_W       = 17;
  localparam logic [16:0] PIN_RESET   = 17'h0E000;
  localparam int          PIN_EDGE    = 16;
  localparam int          PIN_CE      = 15;
  localparam int          PIN_RD      = 14;
  localparam int          PIN_WR      = 13;

  // Port access state
  typedef enum logic [2:0]
  {
    ACC_IDLE  = 3'b001,
    ACC_READ  = 3'b010,
    ACC_WRITE = 3'b100
  } pcp_acc_t;

endpackage

//--- pcp_port.sv
`timescale 1ns/1ps
// What this block does
// - The port is an 8-bit two-way data bus, a 5-bit address and low-active ce, rd, wr.
// - Registers form a global group and 64 pages of up to 16 registers each.
// - Addresses 0 to 15 always reach the global registers, whatever page is chosen.
// - Address 15 holds the page selector, which picks the page seen at addresses 16 to 31.
// - The 8-bit control registers beyond the 16-address global group are reached through the pages.
// - In level mode data flows into the register while wr and ce are low, held after.
// - In edge mode data is captured when wr or ce rises to end the cycle.
// - A static strap pin, not a register bit, picks level or edge writes.
// - The bus is driven only while ce and rd are low and wr is high, else released.
// - With rd grounded, wr acts as direction and ce as the transfer strobe.
module pcp_port
  import pcp_pkg::*;
#(
  parameter int PAGED_REGS = CTRL_REGS - GLOBAL_SPAN
)
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // Host pins
  input  wire logic              ce_n,
  input  wire logic              rd_n,
  input  wire logic              wr_n,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  // Strap
  input  wire logic              edge_write_select,
  // Core side
  output logic      [DATA_W-1:0] page_select,
  output logic                   wr_pulse,
  output logic      [ADDR_W-1:0] wr_addr,
  output logic      [DATA_W-1:0] wr_page,
  output logic      [DATA_W-1:0] wr_data
);

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // Pin sampling

  logic [PIN_W-1:0] pins;
  logic [PIN_W-1:0] s1_reg;
  logic [PIN_W-1:0] s2_reg;
  logic [PIN_W-1:0] s3_reg;
  logic [PIN_W-1:0] filt_reg;

  assign pins = {edge_write_select, ce_n, rd_n, wr_n, addr, data_in};

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s1_reg <= PIN_RESET;
      s2_reg <= PIN_RESET;
      s3_reg <= PIN_RESET;
    end
    else
    begin
      s1_reg <= pins;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Glitch guard: a bit moves only when two stages agree
  genvar gi;
  generate
    for (gi = 0; gi < PIN_W; gi++)
    begin : g_filt
      always_ff @(posedge clk_sys)
      begin
        if (reset)
          filt_reg[gi] <= PIN_RESET[gi];
        else if (s2_reg[gi] == s3_reg[gi])
          filt_reg[gi] <= s3_reg[gi];
      end
    end
  endgenerate

  logic              edge_mode;
  logic              ce_f;
  logic              rd_f;
  logic              wr_f;
  logic [ADDR_W-1:0] addr_f;
  logic [DATA_W-1:0] din_f;

  assign edge_mode = filt_reg[PIN_EDGE];
  assign ce_f      = filt_reg[PIN_CE];
  assign rd_f      = filt_reg[PIN_RD];
  assign wr_f      = filt_reg[PIN_WR];
  assign addr_f    = filt_reg[ADDR_W+DATA_W-1:DATA_W];
  assign din_f     = filt_reg[DATA_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // Access state

  pcp_acc_t acc_reg;
  pcp_acc_t acc_next;
  logic     rd_active;

  // Drive only for ce, rd low and wr high
  assign rd_active = !ce_f && !rd_f && wr_f;

  // Grounded rd makes wr the direction
  always_comb
  begin
    if (!ce_f && !wr_f)
      acc_next = ACC_WRITE;
    else if (rd_active)
      acc_next = ACC_READ;
    else
      acc_next = ACC_IDLE;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      acc_reg <= ACC_IDLE;
    else
      acc_reg <= acc_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write path

  logic [ADDR_W-1:0] lat_addr_reg;
  logic [DATA_W-1:0] lat_data_reg;
  logic              do_write;
  logic [ADDR_W-1:0] w_addr;
  logic [DATA_W-1:0] w_data;
  logic              edge_end;

  // Last values seen inside the write cycle
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      lat_addr_reg <= 5'h00;
      lat_data_reg <= 8'h00;
    end
    else if (acc_next == ACC_WRITE)
    begin
      lat_addr_reg <= addr_f;
      lat_data_reg <= din_f;
    end
  end

  // Rise of wr or ce ends the cycle
  assign edge_end = (acc_reg == ACC_WRITE) && (acc_next != ACC_WRITE);

  always_comb
  begin
    if (edge_mode)
    begin
      do_write = edge_end;
      w_addr   = lat_addr_reg;
      w_data   = lat_data_reg;
    end
    else
    begin
      do_write = (acc_next == ACC_WRITE);
      w_addr   = addr_f;
      w_data   = din_f;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  logic [DATA_W-1:0] page_reg;
  logic [DATA_W-1:0] glob_mem [GLOBAL_SPAN-1];
  logic [DATA_W-1:0] paged_mem [PAGE_COUNT*PAGE_SIZE];

  // Paged slot decode against the selector
  function automatic logic slot_live(input logic [DATA_W-1:0] pg,
                                     input logic [OFS_W-1:0]  ofs);
    logic [PAGE_IDX_W+OFS_W:0] idx;
    idx = {1'b0, pg[PAGE_IDX_W-1:0], ofs};
    slot_live = (pg < DATA_W'(PAGE_COUNT)) && (idx < (PAGE_IDX_W+OFS_W+1)'(PAGED_REGS));
  endfunction

  logic [PAGE_IDX_W+OFS_W-1:0] w_idx;
  logic [PAGE_IDX_W+OFS_W-1:0] r_idx;
  logic                        w_paged;
  logic                        w_live;

  // Page and slot form one flat index
  assign w_idx   = {page_reg[PAGE_IDX_W-1:0], w_addr[OFS_W-1:0]};
  assign r_idx   = {page_reg[PAGE_IDX_W-1:0], addr_f[OFS_W-1:0]};
  assign w_paged = w_addr[ADDR_W-1];
  assign w_live  = slot_live(page_reg, w_addr[OFS_W-1:0]);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      page_reg <= PAGE_SEL_RESET;
    else if (do_write && w_addr == PAGE_SEL_ADDR)
      page_reg <= w_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      for (int i = 0; i < GLOBAL_SPAN-1; i++)
        glob_mem[i] <= REG_RESET;
    end
    else if (do_write && !w_paged && w_addr != PAGE_SEL_ADDR)
      glob_mem[w_addr[OFS_W-1:0]] <= w_data;
  end

  always_ff @(posedge clk_sys)
  begin
    if (do_write && w_paged && w_live)
      paged_mem[w_idx] <= w_data;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  logic [DATA_W-1:0] rd_val;

  // Whole map seen through five address bits
  always_comb
  begin
    if (addr_f == PAGE_SEL_ADDR)
      rd_val = page_reg;
    else if (!addr_f[ADDR_W-1])
      rd_val = glob_mem[addr_f[OFS_W-1:0]];
    else if (slot_live(page_reg, addr_f[OFS_W-1:0]))
      rd_val = paged_mem[r_idx];
    else
      rd_val = 8'h00;
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end
    else
    begin
      data_out <= rd_active ? rd_val : 8'h00;
      data_oe  <= rd_active;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core side copies

  // Registered so the datapath sees one clean pulse per store
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      wr_pulse <= 1'b0;
      wr_addr  <= 5'h00;
      wr_page  <= 8'h00;
      wr_data  <= 8'h00;
    end
    else
    begin
      wr_pulse <= do_write;
      wr_addr  <= w_addr;
      wr_page  <= page_reg;
      wr_data  <= w_data;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
      page_select <= PAGE_SEL_RESET;
    else
      page_select <= page_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence wr_held_s;
    acc_reg == ACC_WRITE && acc_next == ACC_WRITE;
  endsequence

  sequence wr_done_s;
    acc_reg == ACC_WRITE && acc_next != ACC_WRITE;
  endsequence

  pin_filter_a: assert property ($changed(ce_f) |-> $past(s2_reg[PIN_CE]) == ce_f)
    else $error("ce moved without stage agreement");
  oe_gate_a: assert property (data_oe |-> $past(!ce_f && !rd_f && wr_f))
    else $error("bus driven outside a read");
  oe_off_a: assert property ((!wr_f || ce_f || rd_f) |=> !data_oe)
    else $error("bus not released");
  level_wr_a: assert property (!edge_mode && !ce_f && !wr_f && addr_f == PAGE_SEL_ADDR
                               |=> page_reg == $past(din_f))
    else $error("level write did not pass data");
  edge_hold_a: assert property ((wr_held_s and edge_mode) |=> $stable(page_reg))
    else $error("edge mode stored before the end");
  edge_cap_a: assert property ((wr_done_s and (edge_mode && lat_addr_reg == PAGE_SEL_ADDR))
                               |=> page_reg == $past(lat_data_reg))
    else $error("edge write missed");
  page_read_a: assert property (rd_active && addr_f == PAGE_SEL_ADDR
                                |=> data_out == $past(page_reg))
    else $error("selector readback wrong");
  glob_read_a: assert property (rd_active && !addr_f[ADDR_W-1] && addr_f != PAGE_SEL_ADDR
                                |=> data_out == $past(glob_mem[addr_f[OFS_W-1:0]]))
    else $error("global read wrong");
  empty_zero_a: assert property (rd_active && addr_f[ADDR_W-1]
                                 && !slot_live(page_reg, addr_f[OFS_W-1:0])
                                 |=> data_out == 8'h00)
    else $error("empty slot read not zero");
  pulse_map_a: assert property (wr_pulse |-> $past(do_write) && wr_addr == $past(w_addr))
    else $error("core write pulse mismatch");

endmodule

//--- pcp_host.sv
`timescale 1ns/1ps
module pcp_host
  import pcp_pkg::*;
(
  // Clock
  input  wire logic              clk_sys,
  // Host pins
  output logic                   ce_n,
  output logic                   rd_n,
  output logic                   wr_n,
  output logic      [ADDR_W-1:0] addr,
  output logic      [DATA_W-1:0] data_in,
  // Device drive
  input  wire logic [DATA_W-1:0] data_out,
  input  wire logic              data_oe
);
  logic              drv;
  logic [DATA_W-1:0] hd;
  ////////////////////////////////////////
  // shared data bus
  // No pull on the bus, so a released bus shows the inverse
  assign data_in = data_oe ? data_out : (drv ? hd : ~hd);
  initial
  begin
    ce_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = '0;
    hd = '0;
    drv = 1'b0;
  end
  ////////////////////////////////////////
  // write order
  task automatic wr(input logic alt, input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    addr <= a;
    hd <= d;
    drv <= 1'b1;
    rd_n <= !alt;
    if (alt) wr_n <= 1'b0; else ce_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    if (alt) ce_n <= 1'b0; else wr_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    if (alt) ce_n <= 1'b1; else wr_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    ce_n <= 1'b1;
    wr_n <= 1'b1;
    drv <= 1'b0;
    repeat (4) @(posedge clk_sys);
  endtask
  task automatic rd(input logic alt, input logic [4:0] a, output logic [7:0] d);
    int n;
    @(posedge clk_sys);
    addr <= a;
    rd_n <= !alt;
    wr_n <= 1'b1;
    repeat (3) @(posedge clk_sys);
    if (alt) ce_n <= 1'b0; else ce_n <= 1'b0;
    rd_n <= 1'b0;
    n = 0;
    while (n < 12 && data_oe !== 1'b1)
    begin
      @(posedge clk_sys);
      n++;
    end
    d = (data_oe === 1'b1) ? data_out : 'x;
    repeat (2) @(posedge clk_sys);
    rd_n <= !alt;
    ce_n <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask
endmodule

//--- paged_control_port_tb.sv
`timescale 1ns/1ps
module paged_control_port_tb
  import pcp_pkg::*;
;
  logic              clk_sys, reset, strap, ce_n, rd_n, wr_n, data_oe, wr_pulse;
  logic [ADDR_W-1:0] addr, wr_addr;
  logic [DATA_W-1:0] data_in, data_out, page_select, wr_page, wr_data, v;
  logic [20:0]       last_w;
  int                fail_count = 0, num_checks = 0, pulses = 0, p0;
  ////////////////////////////////////////
  pcp_port DUT (.clk_sys(clk_sys), .reset(reset), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .edge_write_select(strap), .page_select(page_select), .wr_pulse(wr_pulse),
    .wr_addr(wr_addr), .wr_page(wr_page), .wr_data(wr_data));
  pcp_host host (.clk_sys(clk_sys), .ce_n(ce_n), .rd_n(rd_n), .wr_n(wr_n), .addr(addr),
    .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Store pulses are short, so keep the last one
  always @(posedge clk_sys)
    if (wr_pulse === 1'b1)
    begin
      pulses <= pulses + 1;
      last_w <= {wr_addr, wr_page, wr_data};
    end
  ////////////////////////////////////////
  task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    check("page reset", page_select, 8'h00);
    check("oe idle", {7'h00, data_oe}, 8'h00);
    host.rd(0, PAGE_SEL_ADDR, v);
    check("page read", v, 8'h00);
  endtask
  task automatic t_mode(input logic edg, input logic [7:0] d);
    strap <= edg;
    repeat (8) @(posedge clk_sys);
    p0 = pulses;
    v = page_select;
    fork
      host.wr(0, PAGE_SEL_ADDR, d);
      begin
        repeat (11) @(posedge clk_sys);
        #1;
        check("mid write", page_select, edg ? v : d);
        check("oe in write", {7'h00, data_oe}, 8'h00);
      end
    join
    check("page out", page_select, d);
    // Level mode stores once per clock of the six-clock strobe, edge mode once
    check("pulse count", 8'(pulses - p0), edg ? 8'h01 : 8'h06);
    host.rd(0, PAGE_SEL_ADDR, v);
    check("page back", v, d);
  endtask
  task automatic t_global;
    for (int a = 0; a < 15; a += 7) host.wr(0, a[4:0], 8'hA0 + a[7:0]);
    host.wr(0, PAGE_SEL_ADDR, 8'h02);
    for (int a = 0; a < 15; a += 7)
    begin
      host.rd(0, a[4:0], v);
      check("global", v, 8'hA0 + a[7:0]);
    end
  endtask
  // Slot 93 is the last populated one, 95 lies beyond
  task automatic t_paged;
    host.wr(0, PAGE_SEL_ADDR, 8'h00);
    host.wr(0, 5'h10, 8'h3C);
    host.wr(0, PAGE_SEL_ADDR, 8'h01);
    host.wr(0, 5'h10, 8'hC3);
    check("store addr", {3'h0, last_w[20:16]}, 8'h10);
    check("store page", last_w[15:8], 8'h01);
    check("store data", last_w[7:0], 8'hC3);
    host.rd(0, 5'h10, v);
    check("page1 slot", v, 8'hC3);
    host.wr(0, PAGE_SEL_ADDR, 8'h00);
    host.rd(0, 5'h10, v);
    check("page0 slot", v, 8'h3C);
    host.wr(0, PAGE_SEL_ADDR, 8'h05);
    host.wr(0, 5'h1D, 8'h11);
    host.wr(0, 5'h1F, 8'h77);
    host.rd(0, 5'h1D, v);
    check("last slot", v, 8'h11);
    host.rd(0, 5'h1F, v);
    check("empty slot", v, 8'h00);
    host.wr(0, PAGE_SEL_ADDR, 8'h40);
    host.wr(0, 5'h10, 8'h66);
    host.rd(0, 5'h10, v);
    check("no page", v, 8'h00);
  endtask
  task automatic t_alt(input logic [7:0] d);
    host.wr(1, PAGE_SEL_ADDR, d);
    host.rd(1, PAGE_SEL_ADDR, v);
    check("alt wiring", v, d);
    check("oe released", {7'h00, data_oe}, 8'h00);
  endtask
  ////////////////////////////////////////
  initial
  begin
    reset = 1'b1;
    strap = 1'b0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    @(posedge clk_sys);
    t_reset;
    t_mode(0, 8'h05);
    t_global;
    t_paged;
    t_mode(1, 8'h09);
    t_alt(8'h2A);
    strap <= 1'b0;
    t_alt(8'hD4);
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    end_sim;
  end
endmodule
